//--- design/agent_read_port.sv
// read side of one agent port: address decode and registered read data
// assumes the host holds read for one wait cycle and samples in the second
`timescale 1ns/1ns
`default_nettype none

module agent_read_port (
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic        read,
    input  wire logic [3:0]  address,
    input  wire logic [31:0] command_word,
    input  wire logic [31:0] payload_pointer,
    input  wire logic [31:0] mailbox_state,
    input  wire logic [31:0] mask_word,
    output logic             take,
    output logic [31:0]      readdata,
    output logic             readdatavalid
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    mailbox_pkg::port_state_t cur;
    mailbox_pkg::port_state_t next_cur;

    // one read per answer: the cycle after a take is the answer cycle
    assign take = read && !cur.valid;

    // decode, unmapped addresses answer zero
    always_comb begin
        next_cur       = cur;
        next_cur.valid = take;
        if (take) begin
            case (address)
                mailbox_pkg::CMD_OFFSET:   next_cur.readdata = command_word;
                mailbox_pkg::PTR_OFFSET:   next_cur.readdata = payload_pointer;
                mailbox_pkg::STATE_OFFSET: next_cur.readdata = mailbox_state;
                mailbox_pkg::MASK_OFFSET:  next_cur.readdata = mask_word;
                default:                   next_cur.readdata = mailbox_pkg::RESET_WORD;
            endcase
        end
    end

    // register the copy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur.readdata <= mailbox_pkg::RESET_WORD;
            cur.valid    <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    assign readdata      = cur.readdata;
    assign readdatavalid = cur.valid;

endmodule : agent_read_port

`default_nettype wire

//--- design/interprocessor_mailbox.sv
// single-message mailbox between a sending and a receiving processor
// assumes both agent ports run on the mailbox clock; no crossing inside
`timescale 1ns/1ns
`default_nettype none

module interprocessor_mailbox #(
    parameter bit MSG_SPACE_NOTIFY = 1'b0
) (
    input  wire logic                    clock,
    input  wire logic                    resetn,
    input  wire mailbox_pkg::agent_req_t snd_req,
    output mailbox_pkg::agent_rsp_t      snd_rsp,
    input  wire mailbox_pkg::agent_req_t rcv_req,
    output mailbox_pkg::agent_rsp_t      rcv_rsp,
    output logic                         irq_msg,
    output logic                         irq_space
);

    // ------------------------------------------------------------
    // state and derived words
    // ------------------------------------------------------------
    mailbox_pkg::mbox_state_t cur;
    mailbox_pkg::mbox_state_t next_cur;

    logic [31:0] status_word;
    logic [31:0] mask_word;
    logic        snd_msg_addr;
    logic        snd_wait;
    logic        snd_write_take;
    logic        rcv_read_take;
    logic        rcv_consume;
    logic [31:0] snd_readdata;
    logic        snd_readvalid;
    logic [31:0] rcv_readdata;
    logic        rcv_readvalid;

    // ------------------------------------------------------------
    // status and mask words as seen by both ports
    // ------------------------------------------------------------

    // one message deep, so pending and full always agree
    // poll view of the flag
    always_comb begin
        status_word                          = mailbox_pkg::RESET_WORD;
        status_word[mailbox_pkg::PEND_BIT]   = cur.full;
        status_word[mailbox_pkg::FULL_BIT]   = cur.full;
        mask_word                            = mailbox_pkg::RESET_WORD;
        mask_word[mailbox_pkg::PEND_MASK_BIT]  = cur.mask_pend;
        mask_word[mailbox_pkg::SPACE_MASK_BIT] = cur.mask_space;
    end

    // ------------------------------------------------------------
    // sender write acceptance
    // ------------------------------------------------------------

    // only message words stall, so the sender can still poll and mask
    // stall while full
    assign snd_msg_addr   = (snd_req.address == mailbox_pkg::CMD_OFFSET)
                         || (snd_req.address == mailbox_pkg::PTR_OFFSET);
    assign snd_wait       = snd_req.write && snd_msg_addr && cur.full;
    assign snd_write_take = snd_req.write && !snd_wait;

    assign rcv_consume    = rcv_read_take && (rcv_req.address == mailbox_pkg::CMD_OFFSET);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;

        // consume first so that a same-cycle set would win
        // command read clears
        if (rcv_consume) begin
            next_cur.full = 1'b0;
        end

        // sender writes; pointer normally goes before command
        if (snd_write_take) begin
            case (snd_req.address)
                mailbox_pkg::CMD_OFFSET: begin
                    next_cur.command = snd_req.writedata;
                    next_cur.full    = 1'b1;
                end
                mailbox_pkg::PTR_OFFSET: begin
                    next_cur.pointer = snd_req.writedata;
                end
                mailbox_pkg::MASK_OFFSET: begin
                    next_cur.mask_space = snd_req.writedata[mailbox_pkg::SPACE_MASK_BIT];
                end
                default: begin
                    next_cur.mask_space = cur.mask_space;
                end
            endcase
        end

        // receiver may only change its own mask bit
        // other receiver writes dropped
        if (rcv_req.write && (rcv_req.address == mailbox_pkg::MASK_OFFSET)) begin
            next_cur.mask_pend = rcv_req.writedata[mailbox_pkg::PEND_MASK_BIT];
        end
    end

    // register the copy
    // flags and masks clear at reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur.command    <= mailbox_pkg::RESET_WORD;
            cur.pointer    <= mailbox_pkg::RESET_WORD;
            cur.full       <= mailbox_pkg::RESET_FLAG;
            cur.mask_pend  <= mailbox_pkg::RESET_FLAG;
            cur.mask_space <= mailbox_pkg::RESET_FLAG;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // read ports
    // ------------------------------------------------------------

    // sender reads have no side effect on the mailbox
    agent_read_port u_snd_read (
        .clock           (clock),
        .resetn          (resetn),
        .read            (snd_req.read),
        .address         (snd_req.address),
        .command_word    (cur.command),
        .payload_pointer (cur.pointer),
        .mailbox_state   (status_word),
        .mask_word       (mask_word),
        .take            (),
        .readdata        (snd_readdata),
        .readdatavalid   (snd_readvalid)
    );

    agent_read_port u_rcv_read (
        .clock           (clock),
        .resetn          (resetn),
        .read            (rcv_req.read),
        .address         (rcv_req.address),
        .command_word    (cur.command),
        .payload_pointer (cur.pointer),
        .mailbox_state   (status_word),
        .mask_word       (mask_word),
        .take            (rcv_read_take),
        .readdata        (rcv_readdata),
        .readdatavalid   (rcv_readvalid)
    );

    // ------------------------------------------------------------
    // port answers
    // ------------------------------------------------------------
    always_comb begin
        snd_rsp.readdata      = snd_readdata;
        snd_rsp.readdatavalid = snd_readvalid;
        snd_rsp.waitrequest   = snd_wait;
        // receiver never stalls, its latency is fixed
        rcv_rsp.readdata      = rcv_readdata;
        rcv_rsp.readdatavalid = rcv_readvalid;
        rcv_rsp.waitrequest   = 1'b0;
    end

    // ------------------------------------------------------------
    // interrupts, levels from registered state
    // ------------------------------------------------------------

    assign irq_msg   = cur.full && cur.mask_pend;

    // level stays up while empty, so a late unmask still notifies
    // present only when built in
    assign irq_space = MSG_SPACE_NOTIFY && !cur.full && cur.mask_space;

endmodule : interprocessor_mailbox

`default_nettype wire

//--- pkg/mailbox_pkg.sv
// shared constants and carrier types for the interprocessor mailbox
// assumes both agent ports and the mailbox share one clock and one reset
package mailbox_pkg;

    // ------------------------------------------------------------
    // widths and register byte offsets
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W         = 4;
    localparam int unsigned DATA_W         = 32;
    localparam logic [3:0]  CMD_OFFSET     = 4'h0;
    localparam logic [3:0]  PTR_OFFSET     = 4'h4;
    localparam logic [3:0]  STATE_OFFSET   = 4'h8;
    localparam logic [3:0]  MASK_OFFSET    = 4'hc;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned PEND_BIT       = 0;
    localparam int unsigned FULL_BIT       = 1;
    localparam int unsigned PEND_MASK_BIT  = 0;
    localparam int unsigned SPACE_MASK_BIT = 1;
    localparam logic        RESET_FLAG     = 1'b0;
    localparam logic [31:0] RESET_WORD     = 32'h0000_0000;

    // ------------------------------------------------------------
    // timing: answer comes after one wait cycle on both ports
    // ------------------------------------------------------------
    localparam int unsigned READ_WAIT_CYCLES = 1;

    // ------------------------------------------------------------
    // carrier and state types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] address;
        logic              read;
        logic              write;
        logic [DATA_W-1:0] writedata;
    } agent_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic              readdatavalid;
        logic              waitrequest;
    } agent_rsp_t;

    typedef struct packed {
        logic [DATA_W-1:0] readdata;
        logic              valid;
    } port_state_t;

    typedef struct packed {
        logic [DATA_W-1:0] command;
        logic [DATA_W-1:0] pointer;
        logic              full;
        logic              mask_pend;
        logic              mask_space;
    } mbox_state_t;

endpackage : mailbox_pkg

//--- sim/mailbox_asserts.sv
// port checks for the mailbox, bound to its top module
// assumes one clock and an async active-low reset
`timescale 1ns/1ns
`default_nettype none
module mailbox_asserts #(
    parameter bit MSG_SPACE_NOTIFY = 1'b0
) (
    input wire logic                    clock,
    input wire logic                    resetn,
    input wire mailbox_pkg::agent_req_t snd_req,
    input wire mailbox_pkg::agent_rsp_t snd_rsp,
    input wire mailbox_pkg::agent_req_t rcv_req,
    input wire mailbox_pkg::agent_rsp_t rcv_rsp,
    input wire logic                    irq_msg,
    input wire logic                    irq_space
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    logic full_m;
    logic put;
    logic take;
    assign put  = snd_req.write && !snd_rsp.waitrequest && snd_req.address == 4'h0;
    assign take = rcv_req.read && !rcv_rsp.readdatavalid;
    // shadow full flag; set wins, as the design lets it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) full_m <= 1'b0;
        else if (put) full_m <= 1'b1;
        else if (take && rcv_req.address == 4'h0) full_m <= 1'b0;
    end
    sequence answer_s;
        rcv_rsp.readdatavalid ##1 !rcv_rsp.readdatavalid;
    endsequence
    rcv_latency_a: assert property (take |=> answer_s)
        else $error("receiver answer late");
    snd_latency_a: assert property (snd_req.read && !snd_rsp.readdatavalid
        |=> snd_rsp.readdatavalid) else $error("sender answer late");
    rcv_nowait_a: assert property (!rcv_rsp.waitrequest)
        else $error("receiver stalled");
    stall_full_a: assert property (snd_req.write && snd_req.address inside {4'h0, 4'h4}
        |-> snd_rsp.waitrequest == full_m) else $error("stall wrong");
    pend_clear_a: assert property (!full_m |-> !irq_msg)
        else $error("pending irq while empty");
    space_gate_a: assert property (full_m || !MSG_SPACE_NOTIFY |-> !irq_space)
        else $error("space irq while full or off");
    status_bits_a: assert property (take && rcv_req.address == 4'h8
        |=> rcv_rsp.readdata == {30'h0, {2{$past(full_m)}}}) else $error("status bad");
    cmd_space_a: assert property (put |=> !irq_space [*2])
        else $error("space irq after send");
    ptr_keep_a: assert property (take && rcv_req.address != 4'h0 && !rcv_req.write
        && !put |=> $stable(irq_msg)) else $error("non-command read moved irq");
endmodule : mailbox_asserts
`default_nettype wire

//--- sim/mailbox_hosts.sv
// sender and receiver processors as bus masters, index 0 and 1
// assumes requests change 2 ns after the rising edge
`timescale 1ns/1ns
`default_nettype none
module mailbox_hosts (
    input  wire logic                    clock,
    output wire mailbox_pkg::agent_req_t snd_req,
    output wire mailbox_pkg::agent_req_t rcv_req,
    input  wire mailbox_pkg::agent_rsp_t snd_rsp,
    input  wire mailbox_pkg::agent_rsp_t rcv_rsp
);
    mailbox_pkg::agent_req_t req [2];
    wire mailbox_pkg::agent_rsp_t rsp [2];
    assign snd_req = req[0];
    assign rcv_req = req[1];
    assign rsp[0]  = snd_rsp;
    assign rsp[1]  = rcv_rsp;
    initial begin
        req[0] = '0;
        req[1] = '0;
    end
    // hold the write while stalled, bounded
    task automatic wr(input int p, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        #2;
        req[p] = '{address: a, read: 1'b0, write: 1'b1, writedata: d};
        @(negedge clock);
        while (rsp[p].waitrequest && n < 400) begin
            n++;
            @(negedge clock);
        end
        @(posedge clock);
        #2;
        req[p].write = 1'b0;
        // released data shows no stale value
        req[p].writedata = ~d;
    endtask : wr
    // read held through the one wait cycle
    task automatic rd(input int p, input logic [3:0] a);
        @(posedge clock);
        #2;
        req[p].address = a;
        req[p].read = 1'b1;
        repeat (2) @(posedge clock);
        #2;
        req[p].read = 1'b0;
    endtask : rd
endmodule : mailbox_hosts
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench for the mailbox with the space irq built in
// assumes the host model drives both agent ports
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic                    clock;
    logic                    resetn;
    mailbox_pkg::agent_req_t snd_req;
    mailbox_pkg::agent_req_t rcv_req;
    mailbox_pkg::agent_rsp_t snd_rsp;
    mailbox_pkg::agent_rsp_t rcv_rsp;
    logic                    irq_msg;
    logic                    irq_space;
    int                      err_total;
    int                      checks;
    logic [31:0]             exp_q [2][$];
    logic [31:0]             lfsr;
    interprocessor_mailbox #(.MSG_SPACE_NOTIFY(1'b1)) i_dut (.clock(clock), .resetn(resetn),
        .snd_req(snd_req), .snd_rsp(snd_rsp), .rcv_req(rcv_req), .rcv_rsp(rcv_rsp),
        .irq_msg(irq_msg), .irq_space(irq_space));
    mailbox_hosts i_host (.clock(clock), .snd_req(snd_req), .rcv_req(rcv_req),
        .snd_rsp(snd_rsp), .rcv_rsp(rcv_rsp));
    always #25 clock = ~clock;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        if (err_total == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    function automatic logic [31:0] rnd;
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic rd_exp(input int p, input logic [3:0] a, input logic [31:0] e);
        exp_q[p].push_back(e);
        i_host.rd(p, a);
    endtask : rd_exp
    // answers are matched in order, sampled mid-cycle
    always @(negedge clock) begin
        if (snd_rsp.readdatavalid === 1'b1) chk(snd_rsp.readdata, exp_q[0].pop_front());
        if (rcv_rsp.readdatavalid === 1'b1) chk(rcv_rsp.readdata, exp_q[1].pop_front());
    end
    task automatic send_recv(input logic [31:0] c, input logic [31:0] p);
        i_host.wr(0, 4'h4, p);
        i_host.wr(0, 4'h0, c);
        rd_exp(1, 4'h8, 32'h3);
        chk(irq_msg, 1'b1);
        chk(irq_space, 1'b0);
        rd_exp(1, 4'h4, p);
        i_host.wr(1, 4'h0, ~c);
        i_host.wr(1, 4'h4, ~p);
        rd_exp(0, 4'h4, p);
        chk(irq_msg, 1'b1);
        rd_exp(1, 4'h0, c);
        chk(irq_msg, 1'b0);
        chk(irq_space, 1'b1);
        rd_exp(0, 4'h8, 32'h0);
    endtask : send_recv
    initial begin
        logic [31:0] c1;
        clock = 1'b0;
        resetn = 1'b0;
        err_total = 0;
        checks = 0;
        lfsr = 32'h0001_7c3a;
        repeat (16) @(posedge clock);
        #2;
        resetn = 1'b1;
        // every even address reads zero after reset, unmapped ones too
        for (int a = 0; a < 16; a += 2) rd_exp(a % 4 == 0, 4'(a), 32'h0);
        chk(irq_space, 1'b0);
        i_host.wr(0, 4'hc, 32'hffff_ffff);
        rd_exp(1, 4'hc, 32'h2);
        i_host.wr(1, 4'hc, 32'hffff_ffff);
        rd_exp(0, 4'hc, 32'h3);
        chk(irq_space, 1'b1);
        repeat (2) send_recv(rnd(), rnd());
        c1 = rnd();
        i_host.wr(0, 4'h0, c1);
        i_host.wr(0, 4'h8, 32'h0);
        rd_exp(0, 4'h8, 32'h3);
        // second send must wait until the receiver consumes the first
        fork
            i_host.wr(0, 4'h0, ~c1);
            begin
                repeat (6) @(posedge clock);
                #3;
                chk(snd_rsp.waitrequest, 1'b1);
                rd_exp(1, 4'h0, c1);
            end
        join
        i_host.wr(1, 4'hc, 32'h0);
        chk(irq_msg, 1'b0);
        rd_exp(1, 4'h0, ~c1);
        tally_and_finish();
    end
    // hang guard, far beyond the roughly 120 cycles needed
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
endmodule : tb_top
bind interprocessor_mailbox mailbox_asserts #(.MSG_SPACE_NOTIFY(MSG_SPACE_NOTIFY)) i_chk (
    .clock(clock), .resetn(resetn), .snd_req(snd_req), .snd_rsp(snd_rsp),
    .rcv_req(rcv_req), .rcv_rsp(rcv_rsp), .irq_msg(irq_msg), .irq_space(irq_space));
`default_nettype wire
